//--- hw/sfh_fifo.sv
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: one clock, synchronous active-high reset
// Notes:   depth must be a power of two
`timescale 1ns/1ps
`default_nettype none
module sfh_fifo #(
   parameter int WIDTH = 20,
   parameter int DEPTH = 8
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   output logic      [WIDTH-1:0] out_data_o,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wp_q;
   logic [AW:0]      rp_q;
   logic             push;
   logic             pop;

   // ----------------------------------------------------------
   // flags
   // ----------------------------------------------------------
   assign in_ready_o  = (wp_q - rp_q) != (AW+1)'(DEPTH);
   assign out_valid_o = wp_q != rp_q;
   assign out_data_o  = mem[rp_q[AW-1:0]];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   // storage
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wp_q[AW-1:0]] <= in_data_i;
      end
   end

   // pointers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wp_q <= '0;
         rp_q <= '0;
      end else begin
         if (push) begin
            wp_q <= wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= rp_q + 1'b1;
         end
      end
   end
endmodule : sfh_fifo
`default_nettype wire

//--- hw/sfh_master.sv
// Purpose: master that drives an async slave-fifo port through its pins
// Assumes: device flags and data arrive asynchronously, 100 MHz clock
// Notes:   commands queue in an 8-deep fifo; one op at a time on the pins
//
// Behaviour
// R01: after auto-full last word, wait one device clock before commit strobe.
// R02: device shows prior read data when output enable asserts.
// R03: hold read strobe active and inactive at least their least widths.
// R04: chip select goes active with or before the read strobe.
// R05: device drives current entry after read strobe activates, after a delay.
// R06: device drives data only while output enable is active.
// R07: each burst read strobe presents an entry, then advances the pointer.
// R08: present stable fifo select and chip select before a write.
// R09: hold write strobe active and inactive at least their least widths.
// R10: chip select active no later than write strobe activation.
// R11: write data valid before write strobe release, held after it.
// R12: device captures data on write strobe release, then post-increments.
// R13: device updates flags within a delay after write strobe release.
// R14: successive writes fill consecutive device fifo locations.
// R15: commit strobe hands written data to host as a short packet.
// R16: never assert write strobe and commit strobe together.
// R17: commit only after write inactive width, with own least widths.
// R18: keep fifo select unchanged while commit strobe is asserted.
// R19: keep output enable active through a read cycle to see data.
// R20: in auto mode a packet commits once bytes reach auto-commit length.
// R21: select the device fifo through a two-bit select address.
// R22: strobe polarities are configurable.
// R23: device synchronises strobe edges into its own clock.
`timescale 1ns/1ps
`default_nettype none
module sfh_master #(
   parameter int DATA_W = sfh_pkg::DATA_W,
   parameter int DEPTH  = sfh_pkg::FIFO_DEPTH
) (
   input  wire logic                  MCLK_I,
   input  wire logic                  SYS_RST_I,
   input  wire sfh_pkg::sfh_cmd_t     CMD_I,
   input  wire logic                  CMD_VALID_I,
   output logic                       CMD_READY_O,
   input  wire sfh_pkg::sfh_pol_t     POL_I,
   input  wire logic                  AUTO_FULL_I,
   output logic [DATA_W-1:0]          RD_DATA_O,
   output logic                       RD_VALID_O,
   output logic                       BUSY_O,
   output logic [1:0]                 FIFO_SELECT_ADDRESS_O,
   output logic                       FIFO_CHIP_SELECT_O,
   output logic                       FIFO_OUTPUT_ENABLE_O,
   output logic                       FIFO_READ_STROBE_O,
   output logic                       FIFO_WRITE_STROBE_O,
   output logic                       PACKET_COMMIT_STROBE_O,
   input  wire logic [DATA_W-1:0]     FIFO_DATA_I,
   output logic [DATA_W-1:0]          FIFO_DATA_O,
   output logic                       FIFO_DATA_OE_N_O,
   input  wire logic [3:0]            FIFO_FLAGS_I,
   output logic [3:0]                 FIFO_FLAGS_O
);
   localparam int CW = sfh_pkg::CNT_W;
   localparam int WW = $bits(sfh_pkg::sfh_cmd_t);

   typedef enum logic [2:0] {
      SFH_IDLE,
      SFH_SETUP,
      SFH_ACTIVE,
      SFH_RELEASE,
      SFH_HOLD
   } sfh_state_t;

   sfh_state_t          state_q;
   sfh_pkg::sfh_cmd_t   cur_q;
   sfh_pkg::sfh_cmd_t   q_data;
   logic                q_valid;
   logic                q_ready;
   logic                cmd_push;
   logic                commit_wait;
   logic [CW-1:0]       cnt_q;
   logic [CW-1:0]       gap_q;
   logic                last_wr_q;
   logic                full_seen_q;
   logic [DATA_W-1:0]   din_s1_q;
   logic [DATA_W-1:0]   din_s2_q;
   logic [3:0]          flg_s1_q;
   logic [3:0]          flg_s2_q;
   logic                af_s1_q;
   logic                af_s2_q;
   logic                cs_act;
   logic                oe_act;
   logic                rd_act;
   logic                wr_act;
   logic                pe_act;

   // ----------------------------------------------------------
   // command queue
   // ----------------------------------------------------------
   sfh_fifo #(
      .WIDTH (WW),
      .DEPTH (DEPTH)
   ) u_queue (
      .clk_i       (MCLK_I),
      .rst_i       (SYS_RST_I),
      .in_data_i   (CMD_I),
      .in_valid_i  (cmd_push),
      .in_ready_o  (q_ready),
      .out_data_o  (q_data),
      .out_valid_o (q_valid),
      .out_ready_i (state_q == SFH_IDLE && gap_q == '0 && !commit_wait)
   );

   // ----------------------------------------------------------
   // pin input synchronisers
   // ----------------------------------------------------------
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         din_s1_q <= '0;
         din_s2_q <= '0;
         flg_s1_q <= '0;
         flg_s2_q <= '0;
         af_s1_q  <= 1'b0;
         af_s2_q  <= 1'b0;
      end else begin
         din_s1_q <= FIFO_DATA_I;
         din_s2_q <= din_s1_q;
         flg_s1_q <= FIFO_FLAGS_I;
         flg_s2_q <= flg_s1_q;
         af_s1_q  <= AUTO_FULL_I;
         af_s2_q  <= af_s1_q;
      end
   end

   // ----------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------
   // command taken only while ready stands; commit held after an auto-full write
   assign cmd_push    = CMD_VALID_I && CMD_READY_O;
   assign commit_wait = state_q == SFH_IDLE && q_valid && gap_q == '0 && last_wr_q &&
                        full_seen_q && q_data.op == sfh_pkg::SFH_OP_COMMIT;  // R01
   // active levels per phase, before polarity
   always_comb begin
      cs_act = state_q != SFH_IDLE;                                     // R04 R10
      oe_act = cur_q.op == sfh_pkg::SFH_OP_READ &&
               (state_q == SFH_ACTIVE || state_q == SFH_RELEASE);        // R06 R19
      rd_act = cur_q.op == sfh_pkg::SFH_OP_READ && state_q == SFH_ACTIVE; // R03
      wr_act = cur_q.op == sfh_pkg::SFH_OP_WRITE && state_q == SFH_ACTIVE; // R09 R16
      pe_act = cur_q.op == sfh_pkg::SFH_OP_COMMIT && state_q == SFH_ACTIVE; // R15 R16
   end

   // phase state and cycle counter
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         state_q <= SFH_IDLE;
         cnt_q   <= '0;
         cur_q   <= '0;
      end else begin
         case (state_q)
            SFH_IDLE: begin
               if (q_valid && gap_q == '0 && !commit_wait) begin
                  cur_q   <= q_data;
                  state_q <= SFH_SETUP;
                  cnt_q   <= CW'(sfh_pkg::ADDR_SETUP_CYC - 1);            // R08 R21
               end
            end
            SFH_SETUP: begin
               if (cnt_q != '0) begin
                  cnt_q <= cnt_q - 1'b1;
               end else begin
                  state_q <= SFH_ACTIVE;
                  case (cur_q.op)
                     sfh_pkg::SFH_OP_READ:
                        cnt_q <= CW'(sfh_pkg::READ_DATA_CYC + 1);          // R03 R05
                     sfh_pkg::SFH_OP_WRITE:
                        cnt_q <= CW'(sfh_pkg::WRITE_ACT_CYC - 1);          // R09
                     default:
                        cnt_q <= CW'(sfh_pkg::COMMIT_ACT_CYC - 1);         // R17
                  endcase
               end
            end
            SFH_ACTIVE: begin
               if (cnt_q != '0) begin
                  cnt_q <= cnt_q - 1'b1;
               end else begin
                  state_q <= SFH_RELEASE;
                  cnt_q   <= CW'(sfh_pkg::ADDR_HOLD_CYC - 1);             // R11 R18
               end
            end
            SFH_RELEASE: begin
               if (cnt_q != '0) begin
                  cnt_q <= cnt_q - 1'b1;
               end else begin
                  state_q <= SFH_IDLE;
               end
            end
            default: begin
               state_q <= SFH_IDLE;
            end
         endcase
      end
   end

   // inactive gap before next strobe
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         gap_q <= '0;
      end else if (state_q == SFH_RELEASE && cnt_q == '0) begin
         case (cur_q.op)
            sfh_pkg::SFH_OP_READ:  gap_q <= CW'(sfh_pkg::READ_INA_CYC);    // R03
            sfh_pkg::SFH_OP_WRITE: gap_q <= CW'(sfh_pkg::WRITE_INA_CYC);   // R09 R17
            default:               gap_q <= CW'(sfh_pkg::COMMIT_INA_CYC);  // R17
         endcase
      end else if (commit_wait) begin
         gap_q <= CW'(sfh_pkg::DEV_CLK_CYC);                               // R01 R20
      end else if (gap_q != '0) begin
         gap_q <= gap_q - 1'b1;
      end
   end

   // tracks a write that filled an auto-committed packet
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         last_wr_q   <= 1'b0;
         full_seen_q <= 1'b0;
      end else if (state_q == SFH_RELEASE && cnt_q == '0) begin
         last_wr_q   <= cur_q.op == sfh_pkg::SFH_OP_WRITE;                 // R14
         full_seen_q <= 1'b0;
      end else if (state_q == SFH_SETUP || commit_wait) begin
         last_wr_q   <= 1'b0;
         full_seen_q <= 1'b0;
      end else if (last_wr_q && af_s2_q) begin
         full_seen_q <= 1'b1;                                              // R01
      end
   end

   // ----------------------------------------------------------
   // registered pins
   // ----------------------------------------------------------
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         FIFO_SELECT_ADDRESS_O  <= '0;
         FIFO_CHIP_SELECT_O     <= ~POL_I.cs_high;                         // R22
         FIFO_OUTPUT_ENABLE_O   <= ~POL_I.oe_high;                         // R22
         FIFO_READ_STROBE_O     <= ~POL_I.rd_high;                         // R22
         FIFO_WRITE_STROBE_O    <= ~POL_I.wr_high;                         // R22
         PACKET_COMMIT_STROBE_O <= ~POL_I.pe_high;                         // R22
         FIFO_DATA_O            <= '0;
         FIFO_DATA_OE_N_O       <= 1'b1;
      end else begin
         FIFO_SELECT_ADDRESS_O  <= cur_q.fifo_select_address;             // R18 R21
         FIFO_CHIP_SELECT_O     <= ~(cs_act ^ POL_I.cs_high);              // R22
         FIFO_OUTPUT_ENABLE_O   <= ~(oe_act ^ POL_I.oe_high);              // R22
         FIFO_READ_STROBE_O     <= ~(rd_act ^ POL_I.rd_high);              // R22
         FIFO_WRITE_STROBE_O    <= ~(wr_act ^ POL_I.wr_high);              // R22
         PACKET_COMMIT_STROBE_O <= ~(pe_act ^ POL_I.pe_high);              // R22
         FIFO_DATA_O            <= cur_q.data;                             // R11
         FIFO_DATA_OE_N_O       <= ~(cur_q.op == sfh_pkg::SFH_OP_WRITE &&
                                     state_q != SFH_IDLE);                 // R11
      end
   end

   // ----------------------------------------------------------
   // user side results
   // ----------------------------------------------------------
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         RD_DATA_O    <= '0;
         RD_VALID_O   <= 1'b0;
         BUSY_O       <= 1'b0;
         CMD_READY_O  <= 1'b0;
         FIFO_FLAGS_O <= '0;
      end else begin
         RD_VALID_O   <= 1'b0;
         // sample at end of read strobe, after delay and sync
         if (cur_q.op == sfh_pkg::SFH_OP_READ && state_q == SFH_ACTIVE &&
             cnt_q == '0) begin
            RD_DATA_O  <= din_s2_q;                                        // R05 R07
            RD_VALID_O <= 1'b1;
         end
         BUSY_O       <= state_q != SFH_IDLE || q_valid || gap_q != '0;
         CMD_READY_O  <= q_ready && !cmd_push;  // drops after a take, so never stale
         FIFO_FLAGS_O <= flg_s2_q;                                         // R13
      end
   end
endmodule : sfh_master
`default_nettype wire

//--- hw/sfh_pkg.sv
// Purpose: shared constants and types for the async slave-fifo master
// Assumes: 100 MHz clock, times in ns
// Notes:   polarities are configuration inputs of the top module
package sfh_pkg;
   localparam int  CLK_PERIOD_NS      = 10;
   // strobe widths and pin timing in ns (plain defaults)
   localparam int  READ_ACTIVE_NS     = 50;
   localparam int  READ_INACTIVE_NS   = 50;
   localparam int  WRITE_ACTIVE_NS    = 50;
   localparam int  WRITE_INACTIVE_NS  = 70;
   localparam int  COMMIT_ACTIVE_NS   = 50;
   localparam int  COMMIT_INACTIVE_NS = 50;
   localparam int  ADDRESS_SETUP_NS   = 20;
   localparam int  ADDRESS_HOLD_NS    = 20;
   localparam int  READ_DATA_NS       = 70;
   localparam int  DEVICE_CLOCK_NS    = 21;
   // least times round up to whole cycles
   localparam int  READ_ACT_CYC  = (READ_ACTIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int  READ_INA_CYC  = (READ_INACTIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int  WRITE_ACT_CYC = (WRITE_ACTIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int  WRITE_INA_CYC = (WRITE_INACTIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int  COMMIT_ACT_CYC = (COMMIT_ACTIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int  COMMIT_INA_CYC = (COMMIT_INACTIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int  ADDR_SETUP_CYC = (ADDRESS_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int  ADDR_HOLD_CYC  = (ADDRESS_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int  READ_DATA_CYC  = (READ_DATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // one device clock after an auto-committed last word
   localparam int  DEV_CLK_CYC    = (DEVICE_CLOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int  FIFO_DEPTH     = 8;
   localparam int  DATA_W         = 16;
   localparam int  CNT_W          = 8;

   typedef enum logic [1:0] {
      SFH_OP_READ,
      SFH_OP_WRITE,
      SFH_OP_COMMIT
   } sfh_op_t;

   // command word from the user side
   typedef struct packed {
      sfh_op_t             op;
      logic [1:0]          fifo_select_address;
      logic [DATA_W-1:0]   data;
   } sfh_cmd_t;

   // active level of each strobe, 1 = active high
   typedef struct packed {
      logic cs_high;
      logic oe_high;
      logic rd_high;
      logic wr_high;
      logic pe_high;
   } sfh_pol_t;
endpackage : sfh_pkg

//--- verification/sfh_dev_model.sv
// Purpose: behavioural four-fifo device behind the strobe pins
// Assumes: strobes checked at levels from pol_i
// Notes:   counts packets and commit-timing faults for the bench
`timescale 1ns/1ps
`default_nettype none
module sfh_dev_model #(
   parameter int AUTO_LEN = 4,
   parameter int DATA_NS  = 30
) (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire sfh_pkg::sfh_pol_t pol_i,
   input  wire logic [1:0]        addr_i,
   input  wire logic              cs_i,
   input  wire logic              oe_i,
   input  wire logic              rd_i,
   input  wire logic              wr_i,
   input  wire logic              pe_i,
   input  wire logic [15:0]       data_i,
   input  wire logic              data_oe_n_i,
   output logic      [15:0]       bus_o,
   output logic      [3:0]        flags_o,
   output logic                   auto_full_o,
   output logic      [7:0]        pkts_o,
   output logic      [7:0]        viol_o
);
   wire logic cs_a = (cs_i == pol_i.cs_high);
   wire logic oe_a = (oe_i == pol_i.oe_high);
   wire logic rd_a = (rd_i == pol_i.rd_high);
   wire logic wr_a = (wr_i == pol_i.wr_high);
   wire logic pe_a = (pe_i == pol_i.pe_high);
   logic [15:0] mem [4][16];
   logic [3:0]  wp [4];
   logic [3:0]  rp [4];
   int          cnt [4];
   logic [15:0] out_q;
   realtime     t_auto;
   // clear pointers and counts
   always @(posedge clk_i) begin
      if (rst_i) begin
         foreach (wp[i]) begin
            wp[i] = 4'h0;
            rp[i] = 4'h0;
            cnt[i] = 0;
         end
         pkts_o = 8'h00;
         viol_o = 8'h00;
         auto_full_o = 1'b0;
         out_q = 16'h5A5A;
         t_auto = -1000.0;
      end
   end
   // capture on strobe release, then post-increment
   always @(negedge wr_a) begin
      if (!rst_i && cs_a) begin
         mem[addr_i][wp[addr_i]] = data_i;
         wp[addr_i] += 4'h1;
         cnt[addr_i] += 1;
         auto_full_o = (cnt[addr_i] == AUTO_LEN);
         if (auto_full_o) begin
            pkts_o += 8'h01;
            cnt[addr_i] = 0;
            t_auto = $realtime;
         end
      end
   end
   // commit a short packet, note too-early commits
   always @(posedge pe_a) begin
      if (!rst_i) begin
         if ($realtime - t_auto < sfh_pkg::DEVICE_CLOCK_NS || wr_a) viol_o += 8'h01;
         pkts_o += 8'h01;
         cnt[addr_i] = 0;
         auto_full_o = 1'b0;
      end
   end
   // present the current entry, then advance
   always @(posedge rd_a) begin
      if (!rst_i && cs_a) begin
         out_q <= #(DATA_NS) mem[addr_i][rp[addr_i]];
         rp[addr_i] += 4'h1;
      end
   end
   // bus: master write data, device data under enable, else a wrong value
   assign bus_o = !data_oe_n_i ? data_i : (oe_a ? out_q : ~out_q);
   assign #5 flags_o = {2'h0, auto_full_o, wp[addr_i] == rp[addr_i]};
endmodule : sfh_dev_model
`default_nettype wire

//--- verification/sfh_master_checker.sv
// Purpose: concurrent checks on the strobe pins of the fifo master
// Assumes: one clock, synchronous active-high reset, polarity static
// Notes:   strobes are judged at their active level taken from POL_I
`timescale 1ns/1ps
`default_nettype none
module sfh_master_checker #(
   parameter int DATA_W = 16
) (
   input  wire logic              MCLK_I,
   input  wire logic              SYS_RST_I,
   input  wire sfh_pkg::sfh_pol_t POL_I,
   input  wire logic [1:0]        FIFO_SELECT_ADDRESS_O,
   input  wire logic              FIFO_CHIP_SELECT_O,
   input  wire logic              FIFO_OUTPUT_ENABLE_O,
   input  wire logic              FIFO_READ_STROBE_O,
   input  wire logic              FIFO_WRITE_STROBE_O,
   input  wire logic              PACKET_COMMIT_STROBE_O,
   input  wire logic [DATA_W-1:0] FIFO_DATA_O,
   input  wire logic              FIFO_DATA_OE_N_O,
   input  wire logic [3:0]        FIFO_FLAGS_I,
   input  wire logic [3:0]        FIFO_FLAGS_O
);
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (SYS_RST_I);
   // active levels after polarity
   wire logic cs_a = (FIFO_CHIP_SELECT_O == POL_I.cs_high);
   wire logic oe_a = (FIFO_OUTPUT_ENABLE_O == POL_I.oe_high);
   wire logic rd_a = (FIFO_READ_STROBE_O == POL_I.rd_high);
   wire logic wr_a = (FIFO_WRITE_STROBE_O == POL_I.wr_high);
   wire logic pe_a = (PACKET_COMMIT_STROBE_O == POL_I.pe_high);
   logic [1:0] up_q;
   // edges since reset, for the flag pipeline
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) up_q <= 2'h0;
      else if (up_q != 2'h3) up_q <= up_q + 2'h1;
   end
   property p_rd_cs; rd_a |-> cs_a; endproperty
   a_rd_cs: assert property (p_rd_cs)
      else $error("read strobe without chip select");
   property p_wr_cs; wr_a |-> cs_a; endproperty
   a_wr_cs: assert property (p_wr_cs)
      else $error("write strobe without chip select");
   property p_rd_oe; rd_a |-> oe_a; endproperty
   a_rd_oe: assert property (p_rd_oe)
      else $error("read strobe without output enable");
   property p_rd_wid; $rose(rd_a) |=> rd_a [*8]; endproperty
   a_rd_wid: assert property (p_rd_wid)
      else $error("read strobe too short");
   property p_rd_gap; $fell(rd_a) |-> !rd_a [*5]; endproperty
   a_rd_gap: assert property (p_rd_gap)
      else $error("read gap too short");
   property p_wr_wid; $rose(wr_a) |=> wr_a [*4]; endproperty
   a_wr_wid: assert property (p_wr_wid)
      else $error("write strobe too short");
   property p_wr_gap; $fell(wr_a) |-> !(wr_a || pe_a) [*7]; endproperty
   a_wr_gap: assert property (p_wr_gap)
      else $error("write gap too short");
   property p_pe_wid; $rose(pe_a) |=> pe_a [*4]; endproperty
   a_pe_wid: assert property (p_pe_wid)
      else $error("commit strobe too short");
   property p_pe_addr; pe_a ##1 pe_a |-> $stable(FIFO_SELECT_ADDRESS_O); endproperty
   a_pe_addr: assert property (p_pe_addr)
      else $error("select moved during commit");
   property p_no_both; !(wr_a && pe_a); endproperty
   a_no_both: assert property (p_no_both)
      else $error("write and commit together");
   property p_wr_setup;
      $rose(wr_a) |-> $past(cs_a) && $stable(FIFO_SELECT_ADDRESS_O) && !FIFO_DATA_OE_N_O;
   endproperty
   a_wr_setup: assert property (p_wr_setup)
      else $error("write setup missing");
   property p_wr_data; wr_a |-> !FIFO_DATA_OE_N_O && $stable(FIFO_DATA_O); endproperty
   a_wr_data: assert property (p_wr_data)
      else $error("write data not held");
   property p_flags; up_q == 2'h3 |-> FIFO_FLAGS_O == $past(FIFO_FLAGS_I, 3); endproperty
   a_flags: assert property (p_flags)
      else $error("flags not passed through");
   c_rd: cover property ($fell(rd_a));
   c_wr: cover property ($fell(wr_a));
   c_pe: cover property ($fell(pe_a));
endmodule : sfh_master_checker
bind sfh_master sfh_master_checker #(.DATA_W(DATA_W)) i_sfh_master_checker (
   .MCLK_I, .SYS_RST_I, .POL_I, .FIFO_SELECT_ADDRESS_O, .FIFO_CHIP_SELECT_O,
   .FIFO_OUTPUT_ENABLE_O, .FIFO_READ_STROBE_O, .FIFO_WRITE_STROBE_O,
   .PACKET_COMMIT_STROBE_O, .FIFO_DATA_O, .FIFO_DATA_OE_N_O, .FIFO_FLAGS_I, .FIFO_FLAGS_O);
`default_nettype wire

//--- verification/sfh_master_test.sv
// Purpose: self-checking bench for the fifo master against a device model
// Assumes: 100 MHz clock, inputs driven on falling edges
// Notes:   runs all cases once per strobe polarity
`timescale 1ns/1ps
`default_nettype none
module sfh_master_test;
   logic              mclk;
   logic              sys_rst;
   sfh_pkg::sfh_cmd_t cmd;
   logic              cmd_valid;
   sfh_pkg::sfh_pol_t pol;
   wire logic         cmd_ready, auto_full, rd_valid, busy, cs, oe, rd, wr, pe, oe_n;
   wire logic [15:0]  rd_data, dat_out, bus;
   wire logic [1:0]   addr;
   wire logic [3:0]   flags_in, flags_out;
   wire logic [7:0]   pkts, viol;
   logic [31:0]       seed;
   logic [15:0]       exp_q [$];
   logic [15:0]       words [4][4];
   int                mismatches, checks_done, cycles;
   sfh_master i_sfh_master (.MCLK_I(mclk), .SYS_RST_I(sys_rst), .CMD_I(cmd),
      .CMD_VALID_I(cmd_valid), .CMD_READY_O(cmd_ready), .POL_I(pol),
      .AUTO_FULL_I(auto_full), .RD_DATA_O(rd_data), .RD_VALID_O(rd_valid), .BUSY_O(busy),
      .FIFO_SELECT_ADDRESS_O(addr), .FIFO_CHIP_SELECT_O(cs), .FIFO_OUTPUT_ENABLE_O(oe),
      .FIFO_READ_STROBE_O(rd), .FIFO_WRITE_STROBE_O(wr), .PACKET_COMMIT_STROBE_O(pe),
      .FIFO_DATA_I(bus), .FIFO_DATA_O(dat_out), .FIFO_DATA_OE_N_O(oe_n),
      .FIFO_FLAGS_I(flags_in), .FIFO_FLAGS_O(flags_out));
   sfh_dev_model i_sfh_dev_model (.clk_i(mclk), .rst_i(sys_rst), .pol_i(pol), .addr_i(addr),
      .cs_i(cs), .oe_i(oe), .rd_i(rd), .wr_i(wr), .pe_i(pe), .data_i(dat_out),
      .data_oe_n_i(oe_n), .bus_o(bus), .flags_o(flags_in), .auto_full_o(auto_full),
      .pkts_o(pkts), .viol_o(viol));
   // clock
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic check(input logic [15:0] seen, input logic [15:0] expv);
      checks_done++;
      if (seen !== expv) begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, expv);
      end
   endtask : check
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : wrap_up
   // offer one command, hold it until taken
   task automatic issue(input sfh_pkg::sfh_op_t op, input logic [1:0] a);
      @(negedge mclk);
      seed = lfsr(seed);
      cmd = '{op, a, seed[15:0]};
      cmd_valid = 1'b1;
      while (cmd_ready !== 1'b1) @(negedge mclk);
      @(posedge mclk);
   endtask : issue
   // stop offering and wait for the queue to empty
   task automatic drain();
      @(negedge mclk);
      cmd_valid = 1'b0;
      repeat (4) @(posedge mclk);
      while (busy !== 1'b0) @(posedge mclk);
      repeat (4) @(posedge mclk);
   endtask : drain
   // read results against the oldest note, plus hang limit
   always @(negedge mclk) begin
      cycles++;
      if (rd_valid === 1'b1) begin
         if (exp_q.size() == 0) check(16'h0000, 16'h0001);
         else check(rd_data, exp_q.pop_front());
      end
      if (cycles == 8000) begin
         mismatches++;
         wrap_up();
      end
   end
   // main sequence
   initial begin
      cmd = '0;
      cmd_valid = 1'b0;
      pol = 5'h00;
      sys_rst = 1'b1;
      seed = 32'h3A20D93F;
      for (int p = 0; p < 2; p++) begin
         @(negedge mclk);
         pol = p ? 5'h1F : 5'h00;
         sys_rst = 1'b1;
         repeat (16) @(negedge mclk);
         sys_rst = 1'b0;
         // fill each fifo to the auto length, commit straight after
         for (int a = 0; a < 4; a++) begin
            for (int i = 0; i < 4; i++) begin
               issue(sfh_pkg::SFH_OP_WRITE, a[1:0]);
               words[a][i] = cmd.data;
            end
            issue(sfh_pkg::SFH_OP_COMMIT, a[1:0]);
         end
         drain();
         check({8'h00, pkts}, 16'h0008);
         check({8'h00, viol}, 16'h0000);
         $display("write and commit test done, polarity %0d", p);
         // read all words back, back to back, across the four fifos
         for (int a = 0; a < 4; a++) begin
            for (int i = 0; i < 4; i++) begin
               exp_q.push_back(words[a][i]);
               issue(sfh_pkg::SFH_OP_READ, a[1:0]);
            end
         end
         drain();
         check(16'(exp_q.size()), 16'h0000);
         check({15'h0000, flags_out[0]}, 16'h0001);
         $display("read back test done, polarity %0d", p);
      end
      wrap_up();
   end
endmodule : sfh_master_test
`default_nettype wire
